// *** design/wcs_tick_div.sv ***
// Divider that turns the core clock into the divided low-frequency
// clock, delivered as a one-cycle enable pulse.
// Assumes an active-low reset, asserted asynchronously and released in step with clk_in.
`timescale 1ns/1ns
module wcs_tick_div #(
  parameter int unsigned DIV = 250
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic tick_out
);

  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_r;

  // Free-running count; the registered pulse comes in the cycle after the last count of each period.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count_r == LAST);
      count_r <= (count_r == LAST) ? '0 : count_r + 1'b1;
    end
  end

endmodule // wcs_tick_div

// *** design/wcs_watchdog.sv ***
// Watchdog timer with a command/status register written by the core.
// Assumes register strobes come from logic on clk_sys_in, one cycle each.
//
// Notes on behaviour
// - Enable/reload applies two low-frequency ticks later.
// - Interval write applies one core clock later.
// - Disable applies three low-frequency ticks later.
// - Read returns interval code in bits 2:0.
// - Read bit four shows watchdog active.
// - MSB-clear write loads interval from bits 2:0.
// - Writing A5 enables and clears counter.
// - DE then AD within four clocks disables.
// - Writing FF locks out disable until reset.
// - Timeout after four to code-plus-three increments.
// - Counter overflow forces a system reset.
// - Counter holds when disabled; comparator stays active.
// - Counts per tick; reset leaves it enabled, cleared.
`timescale 1ns/1ns
module wcs_watchdog #(
  parameter int unsigned LF_DIV = wcs_pkg::LF_DIV_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire wcs_pkg::wcs_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_rvalid_out,
  output logic wdog_reset_out,
  output logic lf_osc_force_on_out
);

  logic rst_meta_r;
  logic rst_sync_n_r;
  logic lf_tick;
  logic wr_hit;
  logic [7:0] wdat;
  logic [2:0] ival_r;
  logic enabled_r;
  logic lock_r;
  logic arm_r;
  logic [2:0] gap_r;
  logic en_pend_r;
  logic [1:0] en_cnt_r;
  logic dis_pend_r;
  logic [1:0] dis_cnt_r;
  logic en_apply;
  logic dis_apply;
  logic [wcs_pkg::CNT_W-1:0] count_r;
  logic [wcs_pkg::CNT_W-1:0] limit;

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  wcs_tick_div #(
    .DIV(LF_DIV)
  ) u_div (
    .clk_in(clk_sys_in),
    .rst_n_in(rst_sync_n_r),
    .tick_out(lf_tick)
  );

  assign wr_hit = sfr_req_in.wr && (sfr_req_in.addr == wcs_pkg::WCS_ADDR);
  assign wdat = sfr_req_in.wdata;

  // one clock delay: the new code is seen from the next edge on.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      ival_r <= wcs_pkg::IVAL_RESET;
    end else if (wr_hit && !wdat[wcs_pkg::CMD_BIT]) begin
      ival_r <= wdat[wcs_pkg::IVAL_W-1:0];
    end
  end

  // disable lockout
  // Only a reset clears the lock, so firmware cannot undo it.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      lock_r <= 1'b0;
    end else if (wr_hit && wdat == wcs_pkg::CMD_LOCK) begin
      lock_r <= 1'b1;
    end
  end

  // unknown commands ignored: they neither arm nor cancel the key.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      arm_r <= 1'b0;
      gap_r <= '0;
    end else if (wr_hit && wdat == wcs_pkg::CMD_DISABLE_FIRST) begin
      arm_r <= 1'b1;
      gap_r <= 3'h1;
    end else if (wr_hit && (!wdat[wcs_pkg::CMD_BIT] ||
                 wdat == wcs_pkg::CMD_ENABLE_RELOAD ||
                 wdat == wcs_pkg::CMD_DISABLE_SECOND ||
                 wdat == wcs_pkg::CMD_LOCK)) begin
      arm_r <= 1'b0; // Any known command but DE consumes the armed key; DE restarts it.
    end else if (arm_r) begin
      if (gap_r == wcs_pkg::DISABLE_GAP_CYCLES) begin
        arm_r <= 1'b0; // Window ran out; a late second key is ignored.
      end else begin
        gap_r <= gap_r + 3'h1;
      end
    end
  end

  // enable pending
  // The write is held until the second tick after it, as the counter
  // logic would see it behind a two-stage synchroniser.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      en_pend_r <= 1'b0;
      en_cnt_r <= '0;
    end else if (wr_hit && wdat == wcs_pkg::CMD_ENABLE_RELOAD) begin
      en_pend_r <= 1'b1;
      en_cnt_r <= '0;
    end else if (en_apply) begin
      en_pend_r <= 1'b0;
    end else if (en_pend_r && lf_tick) begin
      en_cnt_r <= en_cnt_r + 2'h1;
    end
  end

  assign en_apply = en_pend_r && lf_tick &&
                    (en_cnt_r == wcs_pkg::ENABLE_DELAY_TICKS - 2'h1);

  // lock check: a locked watchdog never starts a disable.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      dis_pend_r <= 1'b0;
      dis_cnt_r <= '0;
    end else if (wr_hit && wdat == wcs_pkg::CMD_DISABLE_SECOND &&
                 arm_r && !lock_r) begin
      dis_pend_r <= 1'b1;
      dis_cnt_r <= '0;
    end else if (dis_apply || lock_r) begin
      dis_pend_r <= 1'b0;
    end else if (dis_pend_r && lf_tick) begin
      dis_cnt_r <= dis_cnt_r + 2'h1;
    end
  end

  assign dis_apply = dis_pend_r && lf_tick && !lock_r &&
                     (dis_cnt_r == wcs_pkg::DISABLE_DELAY_TICKS - 2'h1);

  // enable on A5; an enable that lands with a disable wins.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      enabled_r <= 1'b1;
    end else if (en_apply) begin
      enabled_r <= 1'b1;
    end else if (dis_apply) begin
      enabled_r <= 1'b0;
    end
  end

  // timeout limit: 4^(code+3) is a single bit at 2*(code+3).
  always_comb begin
    limit = '0;
    // The index reaches 20, so it is worked out five bits wide.
    limit[5'({ival_r, 1'b0}) + 5'(2 * wcs_pkg::IVAL_OFFSET)] = 1'b1;
  end

  // hold when disabled; the counter is not cleared on disable.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      count_r <= '0;
    end else if (en_apply) begin
      count_r <= '0;
    end else if (enabled_r && lf_tick && count_r < limit) begin
      count_r <= count_r + 1'b1;
    end
  end

  // comparator always live, so shrinking the interval can fire it.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      wdog_reset_out <= 1'b0;
    end else if (count_r >= limit) begin
      wdog_reset_out <= 1'b1; // Held until the system reset arrives.
    end
  end

  // While the watchdog runs it needs its clock source kept alive.
  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      lf_osc_force_on_out <= 1'b1;
    end else begin
      lf_osc_force_on_out <= enabled_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      sfr_rdata_out <= 8'h00;
      sfr_rvalid_out <= 1'b0;
    end else begin
      sfr_rvalid_out <= sfr_req_in.rd &&
                        (sfr_req_in.addr == wcs_pkg::WCS_ADDR);
      if (sfr_req_in.rd && sfr_req_in.addr == wcs_pkg::WCS_ADDR) begin
        sfr_rdata_out <= {3'h0, enabled_r, 1'b0, ival_r};
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

endmodule // wcs_watchdog

// *** pkg/wcs_pkg.sv ***
// Package for the watchdog command block: register map, command codes,
// reset values, synchronisation delays and the register access struct.
// Assumes a single 20 MHz core clock; the divided low-frequency clock
// is modelled as a one-cycle enable pulse derived from that clock.
package wcs_pkg;

  // Core clock rate and the nominal divided low-frequency clock rate.
  localparam int unsigned CORE_CLK_HZ = 20_000_000;
  localparam int unsigned LF_CLK_HZ = 80_000;
  // Core clock cycles per divided low-frequency clock period.
  localparam int unsigned LF_DIV_CYCLES = CORE_CLK_HZ / LF_CLK_HZ;

  // Register address of watchdog_command_status.
  localparam logic [7:0] WCS_ADDR = 8'h97;
  localparam logic [7:0] WCS_RESET_VAL = 8'h17;

  // Command values written to watchdog_command_status.
  localparam logic [7:0] CMD_ENABLE_RELOAD = 8'hA5;
  localparam logic [7:0] CMD_DISABLE_FIRST = 8'hDE;
  localparam logic [7:0] CMD_DISABLE_SECOND = 8'hAD;
  localparam logic [7:0] CMD_LOCK = 8'hFF;

  // Field positions.
  localparam int unsigned CMD_BIT = 7;
  localparam int unsigned ACTIVE_BIT = 4;
  localparam int unsigned IVAL_W = 3;
  localparam logic [2:0] IVAL_RESET = 3'h7;

  // Synchronisation delays, in divided low-frequency clock periods.
  localparam logic [1:0] ENABLE_DELAY_TICKS = 2'h2;
  localparam logic [1:0] DISABLE_DELAY_TICKS = 2'h3;
  // Largest core clock gap between the two disable writes.
  localparam logic [2:0] DISABLE_GAP_CYCLES = 3'h4;

  // Timeout is 4^(code+3) increments; the counter needs 2*(7+3)+1 bits.
  localparam int unsigned IVAL_OFFSET = 3;
  localparam int unsigned CNT_W = 21;

  // Special function register access from the core, one cycle wide.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wcs_sfr_req_t;

endpackage : wcs_pkg

// *** testbench/tb_wcs_watchdog.sv ***
// Testbench for the watchdog command block with an integer model.
// Assumes the design runs with a short low-frequency divider.
`timescale 1ns/1ns
module tb_wcs_watchdog;
  localparam int LF = 4;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  wcs_pkg::wcs_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid, wdog, force_on;
  logic [31:0] seed = 32'hF2D5;
  logic [6:0] r;
  int n_errors = 0, n_tests = 0, cyc = 0, ival = 7, act = 1, k;
  wcs_watchdog #(.LF_DIV(LF)) i_dut (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .sfr_req_in(req), .sfr_rdata_out(rdata),
    .sfr_rvalid_out(rvalid), .wdog_reset_out(wdog),
    .lf_osc_force_on_out(force_on));
  // Core clock with a 50 ns period.
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [6:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[6:0];
  endfunction
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Ceiling on run length, so a hang still reaches the report.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One-cycle write strobe, then n idle cycles.
  task automatic w(input logic [7:0] v, input int n);
    @(posedge clk_sys_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h97, wdata: v};
    @(posedge clk_sys_in);
    req <= '0;
    repeat (n) @(posedge clk_sys_in);
  endtask
  // Read, then compare with the model once the answer has settled.
  task automatic rd(input string nm);
    @(posedge clk_sys_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h97, wdata: 8'h00};
    @(posedge clk_sys_in);
    req <= '0;
    @(negedge clk_sys_in);
    chk(nm, {7'h00, rvalid}, 8'h01);
    chk(nm, rdata, {3'h0, act[0], 1'b0, ival[2:0]});
    chk(nm, {7'h00, force_on}, {7'h00, act[0]});
    chk(nm, {7'h00, wdog}, 8'h00);
  endtask
  task automatic rst();
    reset_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    ival = 7;
    act = 1;
  endtask
  // Full disable, then wait out the three-tick delay.
  task automatic dis();
    w(8'hDE, 0);
    w(8'hAD, 4 * LF);
    act = 0;
  endtask
  initial begin
    rst();
    rd("reset");
    dis();
    rd("disable");
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      w({1'b0, r}, 0);
      ival = r[2:0];
      rd("interval");
      repeat (LF) @(posedge clk_sys_in);
    end
    w(8'h07, LF);
    ival = 7;
    w(8'hA5, 4 * LF);
    act = 1;
    rd("enable");
    w({5'h12, r[2:0]}, 0);
    w(8'hAD, 4 * LF);
    rd("unknown");
    w(8'hDE, 6);
    w(8'hAD, 4 * LF);
    rd("late key");
    w(8'hFF, LF);
    w(8'hDE, 0);
    w(8'hAD, 4 * LF);
    rd("locked");
    rst();
    dis();
    w(8'h00, LF);
    w(8'hA5, 0);
    k = 0;
    while (!wdog && k < 400) begin
      @(posedge clk_sys_in);
      k++;
    end
    chk("timeout", 8'(k >= 60 * LF && k <= 70 * LF), 8'h01);
    rst();
    chk("bite cleared", {7'h00, wdog}, 8'h00);
    rd("after bite");
    tally_and_finish();
  end
endmodule // tb_wcs_watchdog

// *** testbench/wcs_watchdog_checker.sv ***
// Checker for the watchdog command block, bound to its top module.
// Assumes one-cycle bus strobes and LF_DIV of at least 4.
`timescale 1ns/1ns
module wcs_watchdog_checker #(
  parameter int unsigned LF_DIV = 4
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire wcs_pkg::wcs_sfr_req_t sfr_req_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_rvalid_out,
  input wire logic wdog_reset_out,
  input wire logic lf_osc_force_on_out
);
  localparam int EN_MAX = 3 * LF_DIV + 3;
  localparam int DIS_MAX = 3 * LF_DIV + 3;
  logic rd_v, wr_v, lock_r, on;
  logic [7:0] d;
  // Decoded strobes, so the properties stay short.
  assign rd_v = sfr_req_in.rd && sfr_req_in.addr == 8'h97;
  assign wr_v = sfr_req_in.wr && sfr_req_in.addr == 8'h97;
  assign d = sfr_req_in.wdata;
  assign on = lf_osc_force_on_out;
  // A lock write is remembered until the next device reset.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lock_r <= 1'b0;
    end else if (wr_v && d == 8'hFF) begin
      lock_r <= 1'b1;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_dis;
    wr_v && d == 8'hDE && !lock_r ##[1:4] wr_v && d == 8'hAD && on;
  endsequence
  a_read_answer: assert property (rd_v |=> sfr_rvalid_out)
    else $error("read not answered");
  a_read_cause: assert property (sfr_rvalid_out |-> $past(rd_v))
    else $error("answer without read");
  a_read_fields: assert property (sfr_rvalid_out |->
    sfr_rdata_out[7:5] == 3'h0 && !sfr_rdata_out[3])
    else $error("reserved read bits set");
  a_ival_load: assert property (wr_v && !d[7] ##2 rd_v |=>
    sfr_rdata_out[2:0] == $past(sfr_req_in.wdata[2:0], 3))
    else $error("interval not loaded");
  a_enable_delay: assert property (wr_v && d == 8'hA5 && !on |->
    ##[1:EN_MAX] on)
    else $error("enable too late");
  a_enable_early: assert property (wr_v && d == 8'hA5 && !on |->
    ##1 !on [*4])
    else $error("enable too early");
  a_disable_delay: assert property (s_dis |-> ##[1:DIS_MAX] !on)
    else $error("disable too late");
  a_disable_early: assert property (s_dis |=> on [*4])
    else $error("disable too early");
  a_lock_keep: assert property (lock_r && on |=> on)
    else $error("locked watchdog stopped");
  a_reset_sticky: assert property (wdog_reset_out |=> wdog_reset_out)
    else $error("watchdog reset dropped");
  c_read: cover property (rd_v ##1 sfr_rvalid_out);
  c_disable: cover property (s_dis ##[1:DIS_MAX] !on);
  c_bite: cover property ($rose(wdog_reset_out));
endmodule // wcs_watchdog_checker

bind wcs_watchdog wcs_watchdog_checker #(.LF_DIV(LF_DIV)) i_chk (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
  .sfr_rvalid_out(sfr_rvalid_out), .wdog_reset_out(wdog_reset_out),
  .lf_osc_force_on_out(lf_osc_force_on_out));
